// ===== rtl/stack_guard_pkg.sv
// constants and carrier types for the stack limit and secure ram checker
// assumes a 16-bit data space and a stack that steps two addresses per word
package stack_guard_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] SFR_SPACE_TOP = 16'h0800;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam int PC_HI_W = 7;
  localparam int STATUS_LOW_W = 8;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_PUSH,
    OP_POP,
    OP_ACCESS
  } stack_op_t;

  // one stack request from the address generator
  typedef struct packed {
    stack_op_t op;
    logic call_push;
    logic exc_push;
    logic [PC_HI_W-1:0] pc_hi;
    logic [STATUS_LOW_W-1:0] status_low_byte;
    logic [15:0] data;
  } stack_req_t;

  // one protected ram segment window
  typedef struct packed {
    logic enable;
    logic [15:0] base;
    logic [15:0] limit;
  } seg_cfg_t;
endpackage

// ===== rtl/stack_guard.sv
// stack pointer, stack limit compare and secure ram access gating
// assumes the cpu sequencer holds off the faulting access when a trap is raised
`timescale 1ns/1ps

// Operation
// - pointer addresses next free word, grows upward
// - pop predecrements, push writes then increments
// - call push zero-extends program counter high part
// - exception push prepends status low byte
// - stack limit register not reset
// - limit bit zero always zero
// - only push pointer address compared with limit
// - push at limit raises overflow trap
// - stack access address below 0x0800 raises underflow trap
// - boot secure ram only from boot flash
// - segment secure ram only from secure flash
// - master clear low resets the block except the stack limit register
module stack_guard import stack_guard_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic master_clear_n,
  // stack limit write
  input wire logic limit_wr,
  input wire logic [15:0] limit_wdata,
  // stack request
  input wire stack_req_t req,
  // protected ram configuration and code origin
  input wire seg_cfg_t boot_secure_ram,
  input wire seg_cfg_t segment_secure_ram,
  input wire logic exec_in_boot_flash,
  input wire logic exec_in_secure_flash,
  input wire logic data_valid,
  input wire logic data_wr,
  input wire logic [15:0] data_addr,
  input wire logic [15:0] ram_rdata,
  // stack outputs
  output logic [15:0] working_reg_fifteen,
  output logic [15:0] stack_limit_reg,
  output logic [15:0] effective_address,
  output logic [15:0] push_word,
  output logic stack_mem_we,
  output logic overflow_trap,
  output logic underflow_trap,
  // protected ram outputs
  output logic ram_we,
  output logic [15:0] ram_rdata_out,
  output logic access_blocked
);
  logic [15:0] sp_q, sp_d;
  logic [15:0] limit_q;
  logic [15:0] push_word_q;
  logic we_q;
  logic reset_any;
  assign reset_any = rst | ~master_clear_n;

  // pop reads below the pointer, push writes at it
  wire is_push = req.op == OP_PUSH;
  wire is_pop = req.op == OP_POP;
  wire [15:0] stack_addr = is_pop ? sp_q - WORD_STEP : sp_q;
  wire ovf = is_push && (sp_q == limit_q);
  wire unf = (req.op != OP_NONE) && (stack_addr < SFR_SPACE_TOP);
  wire fault = ovf | unf;
  wire [15:0] call_word = {1'b0, {(15-PC_HI_W){1'b0}}, req.pc_hi};
  wire [15:0] exc_word = {1'b0, req.status_low_byte, req.pc_hi};
  wire [15:0] word_sel = req.exc_push ? exc_word : (req.call_push ? call_word : req.data);

  always_comb begin
    sp_d = sp_q;
    if (!fault && is_push) sp_d = sp_q + WORD_STEP;
    if (!fault && is_pop) sp_d = sp_q - WORD_STEP;
  end

  always_ff @(posedge sys_clk or posedge reset_any) begin
    if (reset_any) begin
      sp_q <= SP_RESET;
      push_word_q <= ZERO_WORD;
      we_q <= 1'b0;
    end else begin
      sp_q <= sp_d;
      push_word_q <= word_sel;
      we_q <= is_push && !fault;
    end
  end

  // no reset here: contents stay unknown until software writes it
  always_ff @(posedge sys_clk) begin
    if (limit_wr) limit_q <= {limit_wdata[15:1], 1'b0};
  end

  assign working_reg_fifteen = sp_q;
  assign stack_limit_reg = limit_q;
  assign effective_address = stack_addr;
  assign push_word = push_word_q;
  assign stack_mem_we = we_q;
  assign overflow_trap = ovf;
  assign underflow_trap = unf;

  // secure ram windows
  logic in_boot;
  logic in_seg;
  ram_window_check #(
    .AW(ADDR_W)
  ) u_boot_window (
    .window(boot_secure_ram),
    .addr(data_addr),
    .hit(in_boot)
  );
  ram_window_check #(
    .AW(ADDR_W)
  ) u_seg_window (
    .window(segment_secure_ram),
    .addr(data_addr),
    .hit(in_seg)
  );
  wire deny = data_valid && ((in_boot && !exec_in_boot_flash) || (in_seg && !exec_in_secure_flash));
  assign access_blocked = deny;
  assign ram_we = data_valid && data_wr && !deny;
  assign ram_rdata_out = deny ? ZERO_WORD : ram_rdata;

  // traps
  overflow_now_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    (is_push && sp_q == limit_q) |-> overflow_trap)
    else $error("overflow not flagged");
  underflow_now_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    (req.op != OP_NONE && stack_addr < SFR_SPACE_TOP) |-> underflow_trap)
    else $error("underflow not flagged");
  overflow_cause_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    overflow_trap |-> (req.op == OP_PUSH && working_reg_fifteen == stack_limit_reg))
    else $error("overflow without cause");
  underflow_cause_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    underflow_trap |-> (req.op != OP_NONE && effective_address < SFR_SPACE_TOP))
    else $error("underflow without cause");
  // pointer movement and stack writes
  push_increment_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    (is_push && !fault) |=> sp_q == $past(sp_q) + WORD_STEP)
    else $error("push did not increment");
  pop_decrement_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    (is_pop && !fault) |=> working_reg_fifteen == $past(working_reg_fifteen) - WORD_STEP)
    else $error("pop did not decrement");
  idle_hold_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    (req.op == OP_NONE || req.op == OP_ACCESS) |=> working_reg_fifteen == $past(working_reg_fifteen))
    else $error("pointer moved without push or pop");
  pop_predec_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    is_pop |-> effective_address == sp_q - WORD_STEP)
    else $error("pop not predecremented");
  push_at_sp_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    is_push |-> effective_address == sp_q)
    else $error("push address wrong");
  access_at_sp_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    (req.op == OP_ACCESS) |-> effective_address == working_reg_fifteen)
    else $error("access address wrong");
  fault_hold_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    fault |=> (sp_q == $past(sp_q) && !stack_mem_we))
    else $error("faulting access completed");
  push_store_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    (is_push && !fault) |=> stack_mem_we)
    else $error("push not stored");
  store_only_push_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    !is_push |=> !stack_mem_we)
    else $error("stack write without push");
  // limit register
  limit_even_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    $past(limit_wr) |-> stack_limit_reg[0] == 1'b0)
    else $error("limit bit zero set");
  limit_load_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    limit_wr |=> stack_limit_reg == {$past(limit_wdata[15:1]), 1'b0})
    else $error("limit not loaded");
  // pushed word
  call_msb_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    (req.call_push && !req.exc_push) |=> push_word[15] == 1'b0)
    else $error("call word msb set");
  call_word_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    (req.call_push && !req.exc_push) |=> push_word == {{(16-PC_HI_W){1'b0}}, $past(req.pc_hi)})
    else $error("call word wrong");
  exc_word_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    req.exc_push |=> push_word[PC_HI_W +: STATUS_LOW_W] == $past(req.status_low_byte))
    else $error("status byte missing");
  exc_pc_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    req.exc_push |=> (push_word[PC_HI_W-1:0] == $past(req.pc_hi) && push_word[15] == 1'b0))
    else $error("exception counter part wrong");
  data_word_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    (!req.call_push && !req.exc_push) |=> push_word == $past(req.data))
    else $error("data word wrong");
  // protected ram
  boot_block_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    (data_valid && in_boot && !exec_in_boot_flash) |-> (!ram_we && ram_rdata_out == ZERO_WORD))
    else $error("boot ram not blocked");
  seg_block_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    (data_valid && in_seg && !exec_in_secure_flash) |-> (!ram_we && access_blocked))
    else $error("segment ram not blocked");
  boot_open_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    (data_valid && in_boot && !in_seg && exec_in_boot_flash) |-> !access_blocked)
    else $error("boot ram wrongly blocked");
  seg_open_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    (data_valid && in_seg && !in_boot && exec_in_secure_flash) |-> !access_blocked)
    else $error("segment ram wrongly blocked");
  ram_pass_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    !access_blocked |-> ram_rdata_out == ram_rdata)
    else $error("open read altered");
  open_write_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    (data_valid && data_wr && !access_blocked) |-> ram_we)
    else $error("open write dropped");
  idle_open_a: assert property (@(posedge sys_clk) disable iff (reset_any)
    !data_valid |-> (!ram_we && !access_blocked))
    else $error("idle bus active");
endmodule

// inclusive address window, one instance per protected ram segment
module ram_window_check import stack_guard_pkg::*; #(
  parameter int AW = ADDR_W
) (
  // window settings
  input wire seg_cfg_t window,
  // address of the current data access
  input wire logic [AW-1:0] addr,
  // address inside an enabled window
  output logic hit
);
  wire above_base = addr >= window.base;
  wire below_limit = addr <= window.limit;
  assign hit = window.enable && above_base && below_limit;
endmodule

// ===== dv/ram_side_model.sv
// far-side data ram reply for the stack guard bench
// assumes one clock; reply changes every cycle so stale data never matches
`timescale 1ns/1ps
module ram_side_model (
  // clock
  input wire logic sys_clk,
  // address in, read data out
  input wire logic [15:0] data_addr,
  output logic [15:0] ram_rdata
);
  logic [15:0] tick_q = 16'h0000;
  always @(posedge sys_clk) tick_q <= tick_q + 16'h0001;
  assign ram_rdata = data_addr ^ tick_q;
endmodule

// ===== dv/stack_guard_tb_top.sv
// self-checking bench for stack_guard with the ram reply model
// assumes a 250 MHz sys_clk and reset by rst or master_clear_n
`timescale 1ns/1ps
module stack_guard_tb_top;
  import stack_guard_pkg::*;
  logic sys_clk = 0, rst = 1, master_clear_n = 1, limit_wr = 0, exec_in_boot_flash = 0, k, last_we = 0;
  logic exec_in_secure_flash = 0, data_valid = 0, data_wr = 0, stack_mem_we, overflow_trap, underflow_trap;
  logic [15:0] limit_wdata = 16'h0000, data_addr = 16'h0000, ram_rdata, exp_sp, exp_word, push_word;
  logic [15:0] working_reg_fifteen, stack_limit_reg, effective_address, ram_rdata_out;
  logic ram_we, access_blocked;
  stack_req_t req = '0;
  seg_cfg_t boot_secure_ram = '0, segment_secure_ram = '0;
  stack_op_t o;
  int fail_count = 0, checks = 0, cyc = 0, i;
  integer seed = 32'h30DF;
  always #2 sys_clk = ~sys_clk;
  stack_guard u_stack_guard (.sys_clk, .rst, .master_clear_n, .limit_wr, .limit_wdata, .req, .boot_secure_ram,
    .segment_secure_ram, .exec_in_boot_flash, .exec_in_secure_flash, .data_valid, .data_wr, .data_addr,
    .ram_rdata, .working_reg_fifteen, .stack_limit_reg, .effective_address, .push_word, .stack_mem_we,
    .overflow_trap, .underflow_trap, .ram_we, .ram_rdata_out, .access_blocked);
  ram_side_model u_ram_side_model (.sys_clk, .data_addr, .ram_rdata);
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic go(input stack_op_t op);
    @(posedge sys_clk) req <= {op, 32'($random(seed)), 1'($random(seed))};
    #1;
  endtask
  // quiet cycle after a limit write keeps pointer reads away from it
  task automatic set_limit(input logic [15:0] v);
    @(posedge sys_clk) limit_wr <= 1'b1;
    limit_wdata <= v;
    @(posedge sys_clk) limit_wr <= 1'b0;
    go(OP_NONE);
  endtask
  function automatic logic [15:0] word_of(stack_req_t r);
    if (r.exc_push) return {1'b0, r.status_low_byte, r.pc_hi};
    if (r.call_push) return {9'h000, r.pc_hi};
    return r.data;
  endfunction
  task automatic give_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      give_verdict;
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    exp_sp = SP_RESET;
    set_limit(16'h1FFF);
    chk("sp", SP_RESET, working_reg_fifteen);
    chk("limit", 16'h1FFE, stack_limit_reg);
    for (i = 0; i < 60; i++) begin
      o = (i == 0) ? OP_POP : stack_op_t'(1 + {$random(seed)} % 3);
      go(o);
      k = o == OP_POP && exp_sp == SP_RESET;
      chk("sp", exp_sp, working_reg_fifteen);
      chk("we", {15'h0, last_we}, {15'h0, stack_mem_we});
      if (last_we) chk("word", exp_word, push_word);
      chk("ea", o == OP_POP ? exp_sp - WORD_STEP : exp_sp, effective_address);
      chk("trap", {15'h0, k}, {14'h0, overflow_trap, underflow_trap});
      last_we = o == OP_PUSH;
      exp_word = word_of(req);
      if (o == OP_PUSH) exp_sp += WORD_STEP;
      if (o == OP_POP && !k) exp_sp -= WORD_STEP;
    end
    go(OP_NONE);
    $display("test stack walk done");
    set_limit(exp_sp + 16'h0001);
    chk("limit", exp_sp, stack_limit_reg);
    go(OP_PUSH);
    chk("ovf", 16'h0001, {15'h0, overflow_trap});
    go(OP_NONE);
    chk("sp", exp_sp, working_reg_fifteen);
    chk("we", 16'h0000, {15'h0, stack_mem_we});
    $display("test overflow done");
    @(posedge sys_clk) boot_secure_ram <= '{1'b1, 16'h1000, 16'h10FF};
    segment_secure_ram <= '{1'b1, 16'h1100, 16'h11FF};
    data_valid <= 1'b1;
    for (i = 0; i < 16; i++) begin
      k = i[0];
      @(posedge sys_clk) exec_in_boot_flash <= k ^ i[1];
      exec_in_secure_flash <= k ^ !i[1];
      data_wr <= i[2];
      data_addr <= {7'h08, i[1], 8'($random(seed))};
      #1 chk("blk", {15'h0, !k}, {15'h0, access_blocked});
      chk("ram_we", {15'h0, k & i[2]}, {15'h0, ram_we});
      chk("rd", k ? ram_rdata : 16'h0000, ram_rdata_out);
    end
    @(posedge sys_clk) exec_in_boot_flash <= 1'b0;
    exec_in_secure_flash <= 1'b0;
    data_addr <= 16'h0FFF;
    #1 chk("blk", 16'h0000, {15'h0, access_blocked});
    @(posedge sys_clk) data_addr <= 16'h1200;
    #1 chk("blk", 16'h0000, {15'h0, access_blocked});
    @(posedge sys_clk) data_addr <= 16'h10FF;
    #1 chk("blk", 16'h0001, {15'h0, access_blocked});
    @(posedge sys_clk) boot_secure_ram.enable <= 1'b0;
    #1 chk("blk", 16'h0000, {15'h0, access_blocked});
    $display("test secure ram done");
    set_limit(16'h1FFE);
    go(OP_PUSH);
    go(OP_NONE);
    chk("sp", exp_sp + WORD_STEP, working_reg_fifteen);
    @(posedge sys_clk) master_clear_n <= 1'b0;
    #1 chk("sp", SP_RESET, working_reg_fifteen);
    chk("we", 16'h0000, {15'h0, stack_mem_we});
    chk("word", 16'h0000, push_word);
    @(posedge sys_clk) master_clear_n <= 1'b1;
    #1 chk("sp", SP_RESET, working_reg_fifteen);
    chk("limit", 16'h1FFE, stack_limit_reg);
    $display("test master clear done");
    give_verdict;
  end
endmodule
